// ---- ddcr_pkg.sv ----
// Package with register map, field layout and filter chain encodings
//----------------------------------------------------------------------
// Functional notes
// - IF mode field bits 5:4 picks variable IF (00), zero IF (01), quarter-rate IF (10) or test (11).
// - Complex-to-real bit 3 at 0 gives valid I and Q; at 1 only real I with an extra quarter-rate mix.
// - Decimation select 000/001/010/011 picks halfband 1-2, 1-3, 1-4, or 1 alone, ratio doubled when complex.
// - Select 100/101/110 chains halfband one (plus two, plus three) with thirdband two for 3/6/12, doubled when complex.
// - Select 111 takes chain and ratio from the extended field in bits 7:4 of the input select register.
// - The extended field acts only while the primary select is 111 and is ignored otherwise.
// - Extended 0 chains thirdband two with halfbands four to one for 48 complex or 24 real.
// - Extended 2/3/4 put fifthband two ahead of one/two/three halfbands for 10/20/40 complex, halved real.
// - Extended 7/8/9 use thirdband one alone, with fifthband, or with fifthband and halfband two: 3/15/30 only.
// - Q input select bit 2 routes channel A at 0 and channel B at 1 into the quadrature path.
// - I input select bit 0 routes channel A at 0 and channel B at 1 into the in-phase path.
// - In edge-driven channel selection the channel counter wraps to zero after reaching the low nibble.
// - Channel select mode 0 takes the oscillator channel straight from the low nibble.
// - Mode 1000 counts rising edges of the first general pin, mode 1010 those of the second.
//----------------------------------------------------------------------
package ddcr_pkg;
  localparam logic [11:0] DDCR_CTRL_ADDR = 12'h310;
  localparam logic [11:0] DDCR_INSEL_ADDR = 12'h311;
  localparam logic [11:0] DDCR_OSC_ADDR = 12'h314;
  localparam logic [7:0] DDCR_CTRL_RST = 8'h00;
  localparam logic [7:0] DDCR_INSEL_RST = 8'h00;
  localparam logic [7:0] DDCR_OSC_RST = 8'h00;
  localparam logic [7:0] DDCR_INSEL_MASK = 8'hF5;
  localparam int DDCR_IF_LSB = 4;
  localparam int DDCR_C2R_BIT = 3;
  localparam int DDCR_EXT_LSB = 4;
  localparam int DDCR_QSEL_BIT = 2;
  localparam int DDCR_ISEL_BIT = 0;
  localparam int DDCR_MODE_LSB = 4;
  localparam logic [2:0] DDCR_DEC_EXT = 3'h7;
  localparam logic [3:0] DDCR_MODE_DIRECT = 4'h0;
  localparam logic [3:0] DDCR_MODE_PIN_FIRST = 4'h8;
  localparam logic [3:0] DDCR_MODE_PIN_SECOND = 4'hA;
  // Filter enable vector bit positions
  localparam int DDCR_F_HB1 = 0;
  localparam int DDCR_F_HB2 = 1;
  localparam int DDCR_F_HB3 = 2;
  localparam int DDCR_F_HB4 = 3;
  localparam int DDCR_F_TB1 = 4;
  localparam int DDCR_F_TB2 = 5;
  localparam int DDCR_F_FB2 = 6;
  typedef enum logic [1:0] {
    DDCR_IF_VARIABLE,
    DDCR_IF_ZERO,
    DDCR_IF_QUARTER,
    DDCR_IF_TEST
  } ddcr_if_mode_t;
endpackage : ddcr_pkg

// ---- ddcr_regs.sv ----
// Downconverter channel zero configuration registers on APB
`timescale 1ns/1ps
module ddcr_regs
  import ddcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_pin_first,
  input wire logic general_pin_second,
  output ddcr_pkg::ddcr_if_mode_t if_mode,
  output logic complex_to_real,
  output logic q_valid,
  output logic quarter_mix_en,
  output logic [6:0] filter_enable,
  output logic [5:0] decimation_ratio,
  output logic ratio_supported,
  output logic q_input_channel_b,
  output logic i_input_channel_b,
  output logic [3:0] oscillator_channel
);
  import ddcr_pkg::*;

  //--------------------------------------------------------------------
  // Register file and APB slave
  //--------------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] insel_reg, insel_next;
  logic [7:0] osc_reg, osc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [13:0] word;
  logic hit_ctrl, hit_insel, hit_osc, access, wr;

  // Offset 0x311 is not a word multiple, so all offsets act as word indexes
  assign word = paddr[15:2];
  assign hit_ctrl = (word == 14'(DDCR_CTRL_ADDR)) && (paddr[1:0] == 2'h0);
  assign hit_insel = (word == 14'(DDCR_INSEL_ADDR)) && (paddr[1:0] == 2'h0);
  assign hit_osc = (word == 14'(DDCR_OSC_ADDR)) && (paddr[1:0] == 2'h0);
  assign access = psel && !penable;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign pready = 1'b1;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    insel_next = insel_reg;
    osc_next = osc_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (access)
    begin
      err_next = !(hit_ctrl || hit_insel || hit_osc);
      rdata_next = 32'h0;
      if (hit_ctrl)
        rdata_next = {24'h0, ctrl_reg};
      else if (hit_insel)
        rdata_next = {24'h0, insel_reg};
      else if (hit_osc)
        rdata_next = {24'h0, osc_reg};
    end
    if (wr)
    begin
      if (hit_ctrl)
        ctrl_next = pwdata[7:0];
      if (hit_insel)
        insel_next = pwdata[7:0] & DDCR_INSEL_MASK;
      if (hit_osc)
        osc_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= DDCR_CTRL_RST;
      insel_reg <= DDCR_INSEL_RST;
      osc_reg <= DDCR_OSC_RST;
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      insel_reg <= insel_next;
      osc_reg <= osc_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // Read data is captured in setup, so the zero-wait answer is stable
  assign prdata = rdata_reg;
  assign pslverr = err_reg && psel && penable;

  //--------------------------------------------------------------------
  // Filter chain decode
  //--------------------------------------------------------------------
  logic [2:0] dec_sel;
  logic [3:0] ext_sel;
  logic c2r;
  logic [6:0] fen_reg, fen_next;
  logic [5:0] ratio_reg, ratio_next;
  logic sup_reg, sup_next;
  logic [5:0] base;
  logic half_ok;

  assign dec_sel = ctrl_reg[2:0];
  assign ext_sel = insel_reg[DDCR_EXT_LSB +: 4];
  assign c2r = ctrl_reg[DDCR_C2R_BIT];

  always_comb
  begin
    fen_next = 7'h0;
    base = 6'h0;
    half_ok = 1'b1;
    sup_next = 1'b1;
    if (dec_sel != DDCR_DEC_EXT)
    begin
      fen_next[DDCR_F_HB1] = 1'b1;
      unique case (dec_sel)
        3'h0:
        begin
          fen_next[DDCR_F_HB2] = 1'b1;
          base = 6'h4;
        end
        3'h1:
        begin
          fen_next[DDCR_F_HB3:DDCR_F_HB2] = 2'h3;
          base = 6'h8;
        end
        3'h2:
        begin
          fen_next[DDCR_F_HB4:DDCR_F_HB2] = 3'h7;
          base = 6'h10;
        end
        3'h3: base = 6'h2;
        3'h4:
        begin
          fen_next[DDCR_F_TB2] = 1'b1;
          base = 6'h6;
        end
        3'h5:
        begin
          fen_next[DDCR_F_TB2] = 1'b1;
          fen_next[DDCR_F_HB2] = 1'b1;
          base = 6'hC;
        end
        default:
        begin
          fen_next[DDCR_F_TB2] = 1'b1;
          fen_next[DDCR_F_HB3:DDCR_F_HB2] = 2'h3;
          base = 6'h18;
        end
      endcase
    end
    else
    begin
      case (ext_sel)
        4'h0:
        begin
          fen_next[DDCR_F_TB2] = 1'b1;
          fen_next[DDCR_F_HB4:DDCR_F_HB1] = 4'hF;
          base = 6'h30;
        end
        4'h2:
        begin
          fen_next[DDCR_F_FB2] = 1'b1;
          fen_next[DDCR_F_HB1] = 1'b1;
          base = 6'hA;
        end
        4'h3:
        begin
          fen_next[DDCR_F_FB2] = 1'b1;
          fen_next[DDCR_F_HB2:DDCR_F_HB1] = 2'h3;
          base = 6'h14;
        end
        4'h4:
        begin
          fen_next[DDCR_F_FB2] = 1'b1;
          fen_next[DDCR_F_HB3:DDCR_F_HB1] = 3'h7;
          base = 6'h28;
        end
        4'h7:
        begin
          fen_next[DDCR_F_TB1] = 1'b1;
          base = 6'h3;
          half_ok = 1'b0;
        end
        4'h8:
        begin
          fen_next[DDCR_F_TB1] = 1'b1;
          fen_next[DDCR_F_FB2] = 1'b1;
          base = 6'hF;
          half_ok = 1'b0;
        end
        4'h9:
        begin
          fen_next[DDCR_F_TB1] = 1'b1;
          fen_next[DDCR_F_FB2] = 1'b1;
          fen_next[DDCR_F_HB2] = 1'b1;
          base = 6'h1E;
          half_ok = 1'b0;
        end
        default:
        begin
          sup_next = 1'b0;
        end
      endcase
    end
    // Complex output runs at the full ratio, real output at half
    ratio_next = base;
    if (c2r)
    begin
      ratio_next = {1'b0, base[5:1]};
      if (!half_ok)
        sup_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fen_reg <= 7'h0;
      ratio_reg <= 6'h0;
      sup_reg <= 1'b0;
    end
    else
    begin
      fen_reg <= fen_next;
      ratio_reg <= ratio_next;
      sup_reg <= sup_next;
    end
  end

  assign filter_enable = fen_reg;
  assign decimation_ratio = ratio_reg;
  assign ratio_supported = sup_reg;
  assign if_mode = ddcr_if_mode_t'(ctrl_reg[DDCR_IF_LSB +: 2]);
  assign complex_to_real = c2r;
  assign q_valid = !c2r;
  assign quarter_mix_en = c2r;
  assign q_input_channel_b = insel_reg[DDCR_QSEL_BIT];
  assign i_input_channel_b = insel_reg[DDCR_ISEL_BIT];

  //--------------------------------------------------------------------
  // Oscillator channel selection
  //--------------------------------------------------------------------
  logic [1:0] pin_a_sync, pin_b_sync;
  logic pin_a_last, pin_b_last;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] mode;
  logic step;

  assign mode = osc_reg[DDCR_MODE_LSB +: 4];

  // Pins are asynchronous; edges are taken from the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_a_sync <= 2'h0;
      pin_b_sync <= 2'h0;
      pin_a_last <= 1'b0;
      pin_b_last <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      pin_a_sync <= {pin_a_sync[0], general_pin_first};
      pin_b_sync <= {pin_b_sync[0], general_pin_second};
      pin_a_last <= pin_a_sync[1];
      pin_b_last <= pin_b_sync[1];
      cnt_reg <= cnt_next;
    end
  end

  always_comb
  begin
    step = 1'b0;
    if (mode == DDCR_MODE_PIN_FIRST)
      step = pin_a_sync[1] && !pin_a_last;
    else if (mode == DDCR_MODE_PIN_SECOND)
      step = pin_b_sync[1] && !pin_b_last;
    cnt_next = cnt_reg;
    if (step)
    begin
      if (cnt_reg >= osc_reg[3:0])
        cnt_next = 4'h0;
      else
        cnt_next = cnt_reg + 4'h1;
    end
  end

  // Other modes fall back to the direct nibble
  assign oscillator_channel = (mode == DDCR_MODE_PIN_FIRST ||
    mode == DDCR_MODE_PIN_SECOND) ? cnt_reg : osc_reg[3:0];
endmodule : ddcr_regs

// ---- ddcr_regs_assertions.sv ----
// Checker for the downconverter configuration register block
`timescale 1ns/1ps
module ddcr_regs_chk
  import ddcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic general_pin_first,
  input wire logic general_pin_second,
  input wire ddcr_pkg::ddcr_if_mode_t if_mode,
  input wire logic complex_to_real,
  input wire logic q_valid,
  input wire logic quarter_mix_en,
  input wire logic [6:0] filter_enable,
  input wire logic [5:0] decimation_ratio,
  input wire logic ratio_supported,
  input wire logic q_input_channel_b,
  input wire logic i_input_channel_b,
  input wire logic [3:0] oscillator_channel
);
  import ddcr_pkg::*;

  logic [7:0] ctrl_reg, ctrl_next, insel_reg, insel_next, osc_reg, osc_next;
  logic wr_en, mapped;
  // ----------------------------------------
  // Shadow copies of the written registers
  // ----------------------------------------
  assign wr_en = psel && penable && pwrite && pstrb[0] && pready;
  assign mapped = paddr == 32'hC40 || paddr == 32'hC44 || paddr == 32'hC50;
  always_comb
  begin
    ctrl_next = ctrl_reg;
    insel_next = insel_reg;
    osc_next = osc_reg;
    if (wr_en && paddr == 32'hC40) ctrl_next = pwdata[7:0];
    if (wr_en && paddr == 32'hC44) insel_next = pwdata[7:0] & 8'hF5;
    if (wr_en && paddr == 32'hC50) osc_next = pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= 8'h00;
      insel_reg <= 8'h00;
      osc_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      insel_reg <= insel_next;
      osc_reg <= osc_next;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  a_err_unmapped: assert property (
    psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_ok_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_if_mode: assert property (
    if_mode == ddcr_if_mode_t'(ctrl_reg[5:4]))
    else $error("intermediate frequency mode wrong");
  a_c2r_flags: assert property (
    complex_to_real == ctrl_reg[3] &&
    q_valid == !ctrl_reg[3] && quarter_mix_en == ctrl_reg[3])
    else $error("complex to real flags wrong");
  a_in_route: assert property (
    q_input_channel_b == insel_reg[2] && i_input_channel_b == insel_reg[0])
    else $error("input routing wrong");
  a_dec_single: assert property (
    ctrl_reg[3:0] == 4'h3 |=>
    filter_enable == 7'h01 && decimation_ratio == 6'h02)
    else $error("single halfband chain wrong");
  a_ext_deep: assert property (
    ctrl_reg[3:0] == 4'h7 && insel_reg[7:4] == 4'h0 |=>
    decimation_ratio == 6'h30 && ratio_supported)
    else $error("extended deep chain wrong");
  a_ext_nohalf: assert property (
    ctrl_reg[3:0] == 4'hF && insel_reg[7:4] == 4'h7 |=> !ratio_supported)
    else $error("halved third band ratio accepted");
  a_ext_undef: assert property (
    ctrl_reg[2:0] == 3'h7 && insel_reg[7:4] == 4'hF |=>
    !ratio_supported && filter_enable == 7'h00)
    else $error("undefined extended code accepted");
  a_osc_direct: assert property (
    osc_reg[7:4] == 4'h0 && $stable(osc_reg) |->
    oscillator_channel == osc_reg[3:0])
    else $error("direct channel select wrong");
endmodule : ddcr_regs_chk
bind ddcr_regs ddcr_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .general_pin_first, .general_pin_second, .if_mode, .complex_to_real,
  .q_valid, .quarter_mix_en, .filter_enable, .decimation_ratio,
  .ratio_supported, .q_input_channel_b, .i_input_channel_b,
  .oscillator_channel);

// ---- tb.sv ----
// Self-checking bench for the downconverter configuration registers
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import ddcr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb, cnt;
  logic pin_a, pin_b, c2r, q_valid, qmix, qsel, isel, sup;
  ddcr_if_mode_t if_mode;
  logic [6:0] fe;
  logic [5:0] ratio;
  logic [3:0] osc_ch;
  logic [15:0] seed;
  logic [12:0] cr;
  logic [7:0] ins, ctl, osc;
  int err_total, num_checks;
  ddcr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_pin_first(pin_a), .general_pin_second(pin_b),
    .if_mode(if_mode), .complex_to_real(c2r), .q_valid(q_valid),
    .quarter_mix_en(qmix), .filter_enable(fe), .decimation_ratio(ratio),
    .ratio_supported(sup), .q_input_channel_b(qsel),
    .i_input_channel_b(isel), .oscillator_channel(osc_ch));
  // ----------------------------------------
  // Reference model and bus tasks
  // ----------------------------------------
  function automatic logic [12:0] chain(input logic [2:0] d,
    input logic [3:0] e);
    logic [4:0] idx;
    idx = (d == 3'h7) ? {1'b1, e} : {2'h0, d};
    case (idx)
      5'h00: chain = {7'h03, 6'h04};
      5'h01: chain = {7'h07, 6'h08};
      5'h02: chain = {7'h0F, 6'h10};
      5'h03: chain = {7'h01, 6'h02};
      5'h04: chain = {7'h21, 6'h06};
      5'h05: chain = {7'h23, 6'h0C};
      5'h06: chain = {7'h27, 6'h18};
      5'h10: chain = {7'h2F, 6'h30};
      5'h12: chain = {7'h41, 6'h0A};
      5'h13: chain = {7'h43, 6'h14};
      5'h14: chain = {7'h47, 6'h28};
      5'h17: chain = {7'h10, 6'h03};
      5'h18: chain = {7'h50, 6'h0F};
      5'h19: chain = {7'h52, 6'h1E};
      default: chain = 13'h0000;
    endcase
  endfunction : chain
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask : settle
  // Counter moves three edges after the rise, so hold each level three
  task automatic pulse(input logic second);
    @(posedge pclk);
    if (second) pin_b <= 1'b1; else pin_a <= 1'b1;
    repeat (3) @(posedge pclk);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    if ((osc[7:4] == 4'h8 && !second) || (osc[7:4] == 4'hA && second))
      cnt = (cnt >= osc[3:0]) ? 4'h0 : cnt + 4'h1;
    `CHK(osc_ch, cnt)
  endtask : pulse
  task automatic results();
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // ----------------------------------------
  // Clock, reset, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_total++;
    results();
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; pstrb = 4'hF; pin_a = 1'b0;
    pin_b = 1'b0; err_total = 0; num_checks = 0; seed = 16'h77D7;
    cnt = 4'h0; osc = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, (i == 2) ? 32'hC50 : 32'hC40 + 32'(i) * 4, 32'h0);
      `CHK(rd, 32'h0)
    end
    `CHK({fe, ratio, sup}, {7'h03, 6'h04, 1'b1})
    for (int e = 0; e < 16; e++)
      for (int c = 0; c < 16; c++)
      begin
        seed = lfsr(seed);
        ins = {e[3:0], seed[3:0]};
        ctl = {seed[11:8], c[3:0]};
        apb(1'b1, 32'hC44, {seed[15:8], 16'h0, ins});
        apb(1'b1, 32'hC40, {24'h0, ctl});
        settle();
        cr = chain(ctl[2:0], ins[7:4]);
        `CHK(if_mode, ddcr_if_mode_t'(ctl[5:4]))
        `CHK({c2r, q_valid, qmix}, {ctl[3], !ctl[3], ctl[3]})
        `CHK({qsel, isel}, {ins[2], ins[0]})
        // Third-band-one chains have no halved ratio
        `CHK(sup, cr[5:0] != 0 && !(ctl[3] && cr[10]))
        if (cr[5:0] == 0 || !(ctl[3] && cr[10]))
          `CHK({fe, ratio}, {cr[12:6], cr[5:0] >> ctl[3]})
        apb(1'b0, 32'hC44, 32'h0);
        `CHK(rd, {24'h0, ins & 8'hF5})
        apb(1'b0, 32'hC40, 32'h0);
        `CHK(rd, {24'h0, ctl})
      end
    apb(1'b1, 32'hC48, 32'hFF);
    `CHK(er, 1'b1)
    apb(1'b0, 32'hC48, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, 32'hC40, 32'h0);
    `CHK(rd, {24'h0, ctl})
    osc = 8'h82;
    apb(1'b1, 32'hC50, {24'h0, osc});
    settle();
    `CHK(osc_ch, cnt)
    for (int k = 0; k < 5; k++) pulse(k == 2);
    osc = 8'hA2;
    apb(1'b1, 32'hC50, {24'h0, osc});
    for (int k = 0; k < 4; k++) pulse(k != 1);
    seed = lfsr(seed);
    osc = {4'h0, seed[3:0]};
    apb(1'b1, 32'hC50, {24'h0, osc});
    settle();
    `CHK(osc_ch, osc[3:0])
    apb(1'b0, 32'hC50, 32'h0);
    `CHK(rd, {24'h0, osc})
    results();
  end
endmodule : tb
